// File: rtl/fdhw_pkg.sv
package fdhw_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int WINDOW_BYTES = 8192;
  // Host-side strobe timing in ns, rounded up to sys_clk cycles (25 MHz, 40 ns period).
  localparam int SETUP_NS = 40;
  localparam int PULSE_NS = 120;
  localparam int HOLD_NS = 40;
  localparam int CLK_NS = 40;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int PAGE_BYTES = 512;
  localparam int SIG_BYTES = 6;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  typedef enum logic [2:0] {
    FDHW_IDLE,
    FDHW_SETUP,
    FDHW_STROBE,
    FDHW_HOLD
  } fdhw_state_t;
endpackage

// File: rtl/fdhw_strobe_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fdhw_strobe_if;
  logic       start;
  logic       isWrite;
  logic       busy;
  logic [7:0] phaseCnt;
  modport ctrl (output start, output isWrite, input busy, input phaseCnt);
  modport timer (input start, input isWrite, output busy, output phaseCnt);
endinterface
`default_nettype wire

// File: rtl/fdhw_phase_timer.sv
`timescale 1ns/1ps
`default_nettype none
module fdhw_phase_timer
  import fdhw_pkg::*;
(
  input  wire logic    sys_clk,
  input  wire logic    rst,
  fdhw_strobe_if.timer tif
);
  logic [7:0] cnt_r;
  localparam logic [7:0] TOTAL = 8'(SETUP_CYC + PULSE_CYC + HOLD_CYC);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_r <= CNT_RST;
    end else if (tif.start && cnt_r == CNT_RST) begin
      cnt_r <= TOTAL;
    end else if (cnt_r != CNT_RST) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end

  assign tif.busy = (cnt_r != CNT_RST);
  assign tif.phaseCnt = cnt_r;
endmodule
`default_nettype wire

// File: rtl/fdhw_host_port.sv
`timescale 1ns/1ps
`default_nettype none
module fdhw_host_port
  import fdhw_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              reqValid,
  input  wire logic              reqWrite,
  input  wire logic [ADDR_W-1:0] reqAddr,
  input  wire logic [DATA_W-1:0] reqWdata,
  output logic                   reqReady,
  output logic                   rspValid,
  output logic [DATA_W-1:0]      rspRdata,
  output logic [ADDR_W-1:0]      addr,
  output logic                   chip_select_n,
  output logic                   output_enable_n,
  output logic                   write_enable_n,
  input  wire logic [DATA_W-1:0] dataIn,
  output logic [DATA_W-1:0]      dataOut,
  output logic                   dataOe_n
);
  fdhw_strobe_if sif ();
  fdhw_phase_timer u_timer (
    .sys_clk (sys_clk),
    .rst     (rst),
    .tif     (sif)
  );

  fdhw_state_t state_r;
  logic              write_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [DATA_W-1:0] rdata_r;
  logic              rspValid_r;
  logic              csN_r;
  logic              oeN_r;
  logic              weN_r;
  logic              drvN_r;

  // Pins change on the edge that ends the cycle holding the given count: the
  // strobes fall at STROBE_AT, rise at HOLD_AT, and the access ends at LAST_AT.
  localparam logic [7:0] STROBE_AT = 8'(PULSE_CYC + HOLD_CYC + 1);
  localparam logic [7:0] HOLD_AT   = 8'(HOLD_CYC + 1);
  localparam logic [7:0] LAST_AT   = 8'h01;
  localparam logic [7:0] PULSE_LEN = 8'(PULSE_CYC);

  // One decode serves the state machine and the pin logic alike, so a pin edge
  // and the state that explains it cannot drift apart.
  function automatic logic phase_hit(input fdhw_state_t st,
                                     input logic [7:0]  cnt,
                                     input fdhw_state_t want,
                                     input logic [7:0]  at);
    return (st == want) && (cnt == at);
  endfunction

  logic strobeOn;
  logic strobeOff;
  logic accessEnd;
  assign strobeOn  = phase_hit(state_r, sif.phaseCnt, FDHW_SETUP, STROBE_AT);
  assign strobeOff = phase_hit(state_r, sif.phaseCnt, FDHW_STROBE, HOLD_AT);
  assign accessEnd = phase_hit(state_r, sif.phaseCnt, FDHW_HOLD, LAST_AT);

  assign reqReady = (state_r == FDHW_IDLE) && !sif.busy;
  assign sif.start = reqValid && reqReady;
  assign sif.isWrite = reqWrite;

  // The whole transfer runs off one countdown so phase edges are fixed.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= FDHW_IDLE;
    end else begin
      unique case (state_r)
        FDHW_IDLE:   if (sif.start) state_r <= FDHW_SETUP;
        FDHW_SETUP:  if (strobeOn) state_r <= FDHW_STROBE;
        FDHW_STROBE: if (strobeOff) state_r <= FDHW_HOLD;
        FDHW_HOLD:   if (accessEnd) state_r <= FDHW_IDLE;
        default:     state_r <= FDHW_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      write_r <= 1'b0;
      addr_r  <= '0;
      wdata_r <= DATA_RST;
    end else if (sif.start) begin
      write_r <= reqWrite;
      addr_r  <= reqAddr;
      wdata_r <= reqWdata;
    end
  end

  // Strobes go low a full setup time after address settles and rise a hold time
  // before the address may change, since the far end acts on strobe edges alone.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      csN_r <= 1'b1;
      oeN_r <= 1'b1;
      weN_r <= 1'b1;
    end else if (strobeOn) begin
      csN_r <= 1'b0;
      oeN_r <= write_r;
      weN_r <= !write_r;
    end else if (strobeOff) begin
      csN_r <= 1'b1;
      oeN_r <= 1'b1;
      weN_r <= 1'b1;
    end
  end

  // Write data is driven across the whole access; for reads the bus stays
  // released so it never fights the device's own drivers.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      drvN_r <= 1'b1;
    end else if (sif.start) begin
      drvN_r <= !reqWrite;
    end else if (accessEnd) begin
      drvN_r <= 1'b1;
    end
  end

  // Data is sampled on the last strobe cycle, when device output has settled.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_r    <= DATA_RST;
      rspValid_r <= 1'b0;
    end else begin
      rspValid_r <= 1'b0;
      if (strobeOff) begin
        rspValid_r <= 1'b1;
        if (!write_r) begin
          rdata_r <= dataIn;
        end
      end
    end
  end

  assign addr            = addr_r;
  assign chip_select_n   = csN_r;
  assign output_enable_n = oeN_r;
  assign write_enable_n  = weN_r;
  assign dataOut         = wdata_r;
  assign dataOe_n        = drvN_r;
  assign rspValid        = rspValid_r;
  assign rspRdata        = rdata_r;

  strobe_excl_a: assert property (@(posedge sys_clk) disable iff (rst)
    !(!oeN_r && !weN_r)) else $error("read and write strobes both low");
  we_needs_cs_a: assert property (@(posedge sys_clk) disable iff (rst)
    !weN_r |-> !csN_r) else $error("write enable without chip select");
  oe_needs_cs_a: assert property (@(posedge sys_clk) disable iff (rst)
    !oeN_r |-> !csN_r) else $error("output enable without chip select");
  no_drive_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    !oeN_r |-> drvN_r) else $error("host drives bus during read");
  addr_stable_a: assert property (@(posedge sys_clk) disable iff (rst)
    !csN_r && $past(!csN_r) |-> $stable(addr_r)) else $error("address moved under strobe");
  strobe_width_a: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(csN_r) |-> !csN_r [*3] ##1 csN_r) else $error("strobe width wrong");
  resp_timing_a: assert property (@(posedge sys_clk) disable iff (rst)
    sif.start |-> ##5 rspValid_r) else $error("response not at fixed delay");
  write_data_a: assert property (@(posedge sys_clk) disable iff (rst)
    !weN_r |-> !drvN_r) else $error("write strobe without driven data");

  // Counts the cycles of the current chip-select pulse for the width checks below.
  logic [7:0] lowCnt_r;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lowCnt_r <= CNT_RST;
    end else if (!csN_r) begin
      lowCnt_r <= lowCnt_r + 8'h01;
    end else begin
      lowCnt_r <= CNT_RST;
    end
  end

  // The far end acts on strobe edges alone, so these watch each access as the pins show it.
  pulse_max_a: assert property (@(posedge sys_clk) disable iff (rst)
    lowCnt_r <= PULSE_LEN) else $error("strobe held too long");
  pulse_len_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(csN_r) |-> lowCnt_r == PULSE_LEN) else $error("strobe pulse length wrong");
  idle_quiet_a: assert property (@(posedge sys_clk) disable iff (rst)
    state_r == FDHW_IDLE |-> csN_r && oeN_r && weN_r && drvN_r) else $error("pins active while idle");
  strobe_state_a: assert property (@(posedge sys_clk) disable iff (rst)
    !csN_r |-> state_r == FDHW_STROBE) else $error("chip select low outside strobe phase");
  strobe_kind_a: assert property (@(posedge sys_clk) disable iff (rst)
    !csN_r |-> oeN_r == write_r && weN_r == !write_r) else $error("strobe does not match access kind");
  setup_addr_a: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(csN_r) |-> $stable(addr_r) && $past(state_r == FDHW_SETUP)) else $error("strobe fell without setup");
  addr_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(csN_r) |-> $stable(addr_r) ##1 $stable(addr_r)) else $error("address moved inside hold");
  wdata_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    !drvN_r && $past(!drvN_r) |-> $stable(wdata_r)) else $error("write data moved while driven");
  drv_release_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(drvN_r) |-> $past(state_r == FDHW_HOLD)) else $error("bus released outside hold");
  rdata_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    !(strobeOff && !write_r) |=> $stable(rdata_r)) else $error("read data moved without a read");
  read_capture_a: assert property (@(posedge sys_clk) disable iff (rst)
    rspValid_r && !write_r |-> rdata_r == $past(dataIn)) else $error("read data not taken from bus");
  rsp_at_rise_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(csN_r) |-> rspValid_r) else $error("response not with strobe release");
  rsp_pulse_a: assert property (@(posedge sys_clk) disable iff (rst)
    rspValid_r |=> !rspValid_r) else $error("response longer than one cycle");
  ready_gap_a: assert property (@(posedge sys_clk) disable iff (rst)
    sif.start |=> !reqReady [*5] ##1 reqReady) else $error("ready gap after request wrong");
endmodule
`default_nettype wire

// File: dv/fdhw_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module fdhw_flash_model
  import fdhw_pkg::*;
(
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              chip_select_n,
  input  wire logic              output_enable_n,
  input  wire logic              write_enable_n,
  input  wire logic [DATA_W-1:0] hostData,
  input  wire logic              hostOe_n,
  output logic [DATA_W-1:0]      busData
);
  logic [DATA_W-1:0] mem [WINDOW_BYTES];
  logic [DATA_W-1:0] lastVal = 8'h00;
  // Mode control sits at an arbitrary offset; its keys and the fixed byte are arbitrary too.
  localparam logic [ADDR_W-1:0] MODE_ADDR = 13'h1FF0;
  localparam logic [DATA_W-1:0] KEY_ENTER = 8'hC3;
  localparam logic [DATA_W-1:0] KEY_LEAVE = 8'h3C;
  localparam logic [DATA_W-1:0] FIXED_RD  = 8'hEE;
  logic              inReset = 1'b0;
  wire               readCyc = !chip_select_n && !output_enable_n;
  wire  [DATA_W-1:0] devByte = inReset ? FIXED_RD : mem[addr];
  // Level sensitive like an SRAM, since the strobes alone start the work.
  always @* begin
    if (!chip_select_n && !write_enable_n) begin
      if (addr == MODE_ADDR) begin
        if (hostData == KEY_ENTER) inReset = 1'b1;
        else if (hostData == KEY_LEAVE) inReset = 1'b0;
      end else if (!inReset) begin
        mem[addr] = hostData;
      end
    end
  end
  always @* begin
    if (readCyc) lastVal = devByte;
    else if (!hostOe_n) lastVal = hostData;
  end
  // A released bus shows the inverse of its last value, so a stale byte never reads back as good.
  assign busData = readCyc ? devByte : (!hostOe_n ? hostData : ~lastVal);
endmodule
`default_nettype wire

// File: dv/fdhw_host_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module fdhw_host_port_tb_top
  import fdhw_pkg::*;
;
  logic              sys_clk = 1'b0;
  logic              rst = 1'b1;
  logic              reqValid = 1'b0;
  logic              reqWrite = 1'b0;
  logic [ADDR_W-1:0] reqAddr = 13'h0000;
  logic [DATA_W-1:0] reqWdata = 8'h00;
  logic              reqReady, rspValid, chip_select_n, output_enable_n, write_enable_n, dataOe_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] rspRdata, dataIn, dataOut;
  int                miscompares = 0;
  int                totalChecks = 0;
  initial forever #20 sys_clk = ~sys_clk;
  fdhw_host_port DUT (.sys_clk, .rst, .reqValid, .reqWrite, .reqAddr, .reqWdata, .reqReady, .rspValid,
    .rspRdata, .addr, .chip_select_n, .output_enable_n, .write_enable_n, .dataIn, .dataOut, .dataOe_n);
  fdhw_flash_model dev (.addr, .chip_select_n, .output_enable_n, .write_enable_n, .hostData(dataOut),
    .hostOe_n(dataOe_n), .busData(dataIn));
  task automatic conclude();
    if (miscompares == 0 && totalChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    totalChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Entered just after a rising edge; for a read, d is the byte expected back.
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int k;
    int lo;
    lo = 0;
    reqValid <= 1'b1;
    reqWrite <= wr;
    reqAddr <= a;
    reqWdata <= d;
    @(posedge sys_clk);
    reqValid <= 1'b0;
    for (k = 0; k < 12 && rspValid !== 1'b1; k++) begin
      @(negedge sys_clk);
      if (chip_select_n === 1'b0) begin
        lo += ((wr ? write_enable_n : output_enable_n) === 1'b0);
        chk(dataOe_n, !wr);
        chk(output_enable_n | write_enable_n, 1'b1);
        chk(addr, a);
      end
    end
    chk(k, SETUP_CYC + PULSE_CYC + HOLD_CYC);
    chk(lo, PULSE_CYC);
    if (!wr) chk(rspRdata, d);
    if (k != SETUP_CYC + PULSE_CYC + HOLD_CYC) conclude();
    @(posedge sys_clk);
  endtask
  task automatic t_reset();
    @(negedge sys_clk);
    chk({chip_select_n, output_enable_n, write_enable_n, dataOe_n, rspValid, reqReady}, 16'h003D);
    @(posedge sys_clk);
  endtask
  task automatic t_edges();
    xfer(1'b1, 13'h0000, 8'hA5);
    xfer(1'b1, 13'h1FFF, 8'h5A);
    xfer(1'b0, 13'h0000, 8'hA5);
    xfer(1'b0, 13'h1FFF, 8'h5A);
  endtask
  // Reset mode drops plain writes and answers reads with the fixed byte until the leave key.
  task automatic t_modes();
    xfer(1'b1, 13'h1FF0, 8'hC3);
    xfer(1'b1, 13'h0000, 8'h11);
    xfer(1'b0, 13'h0000, 8'hEE);
    xfer(1'b1, 13'h1FF0, 8'h3C);
    xfer(1'b0, 13'h0000, 8'hA5);
  endtask
  task automatic t_page();
    for (int i = 0; i < 2 * PAGE_BYTES; i++) begin
      xfer(i < PAGE_BYTES, 13'h0200 + 13'(i % PAGE_BYTES), 8'(i) ^ 8'h3C);
    end
  endtask
  // A reset in mid-write must drop every strobe and free the bus at once.
  task automatic t_midreset();
    reqValid <= 1'b1;
    reqWrite <= 1'b1;
    reqAddr <= 13'h0A00;
    repeat (3) @(posedge sys_clk);
    reqValid <= 1'b0;
    rst <= 1'b1;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk({chip_select_n, write_enable_n, dataOe_n}, 16'h0007);
    @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    xfer(1'b0, 13'h1FFF, 8'h5A);
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_edges();
    t_modes();
    t_page();
    t_midreset();
    conclude();
  end
endmodule
`default_nettype wire
